//--- aite_regs.svh
// Register offsets, field positions, reset values and timing counts of the timing engines.
`ifndef AITE_REGS_SVH
`define AITE_REGS_SVH
`define AITE_NUM_ENG 8
`define AITE_NUM_SLOT 8
`define AITE_OFS_CTRL 5'h00
`define AITE_OFS_DIV 5'h04
`define AITE_OFS_BUFLEN 5'h08
`define AITE_OFS_PRE 5'h0C
`define AITE_OFS_TRIG 5'h10
`define AITE_OFS_SLOTS 5'h14
`define AITE_OFS_CHANS 5'h18
`define AITE_OFS_STAT 5'h1C
`define AITE_OFS_ROUTE 9'h100
`define AITE_CTRL_START 0
`define AITE_CTRL_ABORT 1
`define AITE_CTRL_TBREQ 4:2
`define AITE_CTRL_TBSEL 6:5
`define AITE_CTRL_FAST 23:8
`define AITE_DIV_SAMPLE 15:0
`define AITE_DIV_CONV 31:16
`define AITE_TRIG_REFSRC 4:0
`define AITE_TRIG_REFFALL 5
`define AITE_TRIG_REFEN 6
`define AITE_TRIG_REFINV 7
`define AITE_TRIG_PSRC 12:8
`define AITE_TRIG_PLOW 13
`define AITE_TRIG_PEN 14
`define AITE_SLOT_SCAN 7:0
`define AITE_SLOT_SSH 15:8
`define AITE_SLOT_DS 23:16
`define AITE_SLOT_SLOW 31:24
`define AITE_CTRL_RST 32'h0000_0000
`define AITE_DIV_RST 32'h0000_0001
`define AITE_GEN_RST 32'h0000_0000
`define AITE_CLK_NS 16'h0032
`define AITE_PAD_NS 16'h2710
`define AITE_PAD_CYC ((`AITE_PAD_NS + `AITE_CLK_NS - 16'h0001) / `AITE_CLK_NS)
`endif

//--- aite_pkg.sv
// Types shared by the timing engine modules.
package aite_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE = 3'b001,
      ST_ARMED = 3'b010,
      ST_POST = 3'b011,
      ST_DONE = 3'b100
   } aite_state_t;
   // Codes 1 to 3 follow ascending rate: 10, 12.8, 13.1072 MHz; code 0 is the faster 20 MHz core clock.
   typedef enum logic [1:0] {
      TB_CORE = 2'b00,
      TB_10M = 2'b01,
      TB_12M8 = 2'b10,
      TB_13M1 = 2'b11
   } aite_tb_t;
   typedef struct packed {
      logic [15:0] div;
      logic [15:0] bufLen;
      logic [15:0] pre;
      logic [4:0] refSrc;
      logic refFall;
      logic refEn;
      logic [4:0] pauseSrc;
      logic pauseLow;
      logic pauseEn;
   } aite_cfg_t;
   typedef struct packed {
      aite_state_t state;
      logic done;
      logic trig;
      logic paused;
      logic [15:0] wrPtr;
   } aite_stat_t;
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
   } aite_buf_t;
endpackage

//--- aite_engine.sv
// One input timing engine: sample clock, pause, reference trigger and buffer pointer.
`timescale 1ns/1ps
`default_nettype none
`include "aite_regs.svh"
module aite_engine
   import aite_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control
   input wire aite_cfg_t cfg,
   input wire logic start,
   input wire logic abort,
   input wire logic tick,
   input wire logic [31:0] srcVec,
   // Results
   output logic samplePulse,
   output logic refPulse,
   output aite_buf_t bufOut,
   output aite_stat_t stat
);
   aite_state_t stateQ;
   logic [15:0] divCntQ, cntQ, wrPtrQ, divTop, target, postLen;
   logic srcPrevQ, sampleQ, refQ, doneQ, trigQ, running, paused, refCur, refEdge;
   aite_buf_t bufQ;

   assign running = (stateQ == ST_PRE) || (stateQ == ST_ARMED) || (stateQ == ST_POST);
   assign paused = cfg.pauseEn & (srcVec[cfg.pauseSrc] ^ cfg.pauseLow);
   assign refCur = srcVec[cfg.refSrc];
   assign refEdge = cfg.refFall ? (srcPrevQ & ~refCur) : (refCur & ~srcPrevQ);
   assign divTop = (cfg.div == 16'h0000) ? 16'h0000 : cfg.div - 16'h0001;
   assign target = cfg.refEn ? cfg.pre : cfg.bufLen;
   assign postLen = cfg.bufLen - cfg.pre;
   // A pulse computed in the last running cycle is dropped once the engine has stopped.
   assign samplePulse = sampleQ & running;

   always_ff @(posedge core_clk) begin
      if (sys_rst || start) begin
         divCntQ <= 16'h0000;
         sampleQ <= 1'b0;
      end else if (running && tick && !paused) begin
         divCntQ <= (divCntQ >= divTop) ? 16'h0000 : divCntQ + 16'h0001;
         sampleQ <= divCntQ >= divTop;
      end else begin
         sampleQ <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         srcPrevQ <= 1'b0;
      end else begin
         srcPrevQ <= refCur;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || abort) begin
         stateQ <= ST_IDLE;
         cntQ <= 16'h0000;
         refQ <= 1'b0;
         doneQ <= 1'b0;
         trigQ <= 1'b0;
      end else if (start) begin
         stateQ <= (cfg.refEn && cfg.pre == 16'h0000) ? ST_ARMED : ST_PRE;
         cntQ <= 16'h0000;
         refQ <= 1'b0;
         doneQ <= 1'b0;
         trigQ <= 1'b0;
      end else begin
         refQ <= 1'b0;
         unique case (stateQ)
            ST_IDLE, ST_DONE: begin
            end
            ST_PRE: begin
               // Reference edges are not looked at here.
               if (samplePulse) begin
                  cntQ <= cntQ + 16'h0001;
                  if (cntQ + 16'h0001 >= target) begin
                     stateQ <= cfg.refEn ? ST_ARMED : ST_DONE;
                     doneQ <= !cfg.refEn;
                  end
               end
            end
            ST_ARMED: begin
               if (refEdge) begin
                  trigQ <= 1'b1;
                  refQ <= 1'b1;
                  cntQ <= postLen;
                  stateQ <= (postLen == 16'h0000) ? ST_DONE : ST_POST;
                  doneQ <= postLen == 16'h0000;
               end
            end
            ST_POST: begin
               if (samplePulse) begin
                  cntQ <= cntQ - 16'h0001;
                  if (cntQ == 16'h0001) begin
                     stateQ <= ST_DONE;
                     doneQ <= 1'b1;
                  end
               end
            end
            default: stateQ <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || start) begin
         wrPtrQ <= 16'h0000;
         bufQ <= '0;
      end else begin
         bufQ.wr <= samplePulse;
         bufQ.addr <= wrPtrQ;
         if (samplePulse) begin
            // Wrapping overwrites the oldest sample while waiting for the trigger.
            wrPtrQ <= (wrPtrQ + 16'h0001 >= cfg.bufLen) ? 16'h0000 : wrPtrQ + 16'h0001;
         end
      end
   end

   assign refPulse = refQ;
   assign bufOut = bufQ;
   assign stat = '{state: stateQ, done: doneQ, trig: trigQ, paused: paused, wrPtr: wrPtrQ};
endmodule
`default_nettype wire

//--- aite_top.sv
// Analog input timing engines with AHB-Lite registers, convert sequencing and slot pulses.
`timescale 1ns/1ps
`default_nettype none
`include "aite_regs.svh"
module aite_top
   import aite_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Timebase ticks: 10, 12.8 and 13.1072 MHz enables
   input wire logic [2:0] tbTick,
   // Trigger sources
   input wire logic [7:0] programmableFunctionTerminalIn,
   input wire logic [7:0] internalSig,
   input wire logic [7:0] compareEvent,
   // Terminal outputs
   output logic [7:0] programmableFunctionTerminalOut,
   output logic [7:0] programmableFunctionTerminalOe,
   // Module slots
   output logic [7:0] convPulse,
   output logic [7:0] simultaneousSampleHold,
   output logic [7:0] dsSync,
   output logic [7:0] osTick,
   input wire logic [7:0] dsSampleClk,
   output logic [7:0] slowSample,
   input wire logic [7:0] slowBusy,
   output logic [7:0] sampleRepeat,
   // Sample buffer write side
   output aite_buf_t [7:0] bufPort
);
   logic aPhQ, aWrQ, rdDoneQ, dataWr;
   logic [8:0] aAddrQ;
   logic [31:0] hrdataQ, routeQ, rdMux;
   logic [31:0] rdEng [0:7];
   logic [31:0] srcVec;
   logic [7:0] sampleE, refE, invE, tickE;
   logic [7:0] convE [0:7];
   logic [7:0] sshE [0:7];
   logic [7:0] syncE [0:7];
   logic [7:0] slowE [0:7];
   logic [7:0] repE [0:7];
   logic [7:0] osE [0:7];
   logic [7:0] pfiOutQ;

   assign srcVec = {8'h00, compareEvent, internalSig, programmableFunctionTerminalIn};

   function automatic logic [3:0] maxChans(input logic [31:0] chans, input logic [7:0] mask);
      logic [3:0] m;
      m = 4'h0;
      for (int s = 0; s < `AITE_NUM_SLOT; s++) begin
         if (mask[s] && chans[4*s +: 4] > m) begin
            m = chans[4*s +: 4];
         end
      end
      return m;
   endfunction

   // Reads take one wait state so that read data always leaves a flip-flop.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         aPhQ <= 1'b0;
         aWrQ <= 1'b0;
         aAddrQ <= 9'h000;
      end else if (hready) begin
         aPhQ <= hsel & htrans[1];
         aWrQ <= hwrite;
         aAddrQ <= haddr[8:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdDoneQ <= 1'b0;
         hrdataQ <= 32'h0000_0000;
      end else begin
         rdDoneQ <= aPhQ & !aWrQ & !rdDoneQ;
         if (aPhQ && !aWrQ && !rdDoneQ) begin
            hrdataQ <= rdMux;
         end
      end
   end

   always_comb begin
      if (!aAddrQ[8]) begin
         rdMux = rdEng[aAddrQ[7:5]];
      end else if (aAddrQ == `AITE_OFS_ROUTE) begin
         rdMux = routeQ;
      end else begin
         rdMux = 32'h0000_0000;
      end
   end

   assign dataWr = aPhQ & aWrQ;
   assign hreadyout = !(aPhQ && !aWrQ && !rdDoneQ);
   assign hresp = 1'b0;
   assign hrdata = hrdataQ;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         routeQ <= `AITE_GEN_RST;
      end else if (dataWr && aAddrQ == `AITE_OFS_ROUTE) begin
         routeQ <= hwdata;
      end
   end

   // Eight engines, each with its own register block and convert sequencer.
   for (genvar e = 0; e < `AITE_NUM_ENG; e++) begin : g_eng
      logic [31:0] ctrlQ, divQ, bufQ, preQ, trigQ, slotQ, chanQ;
      logic weE, startP, abortP, emit;
      logic [3:0] maxCh, idxQ;
      logic [15:0] gapQ, perCntQ, lastPerQ, spacing, padded, even;
      logic [19:0] need;
      logic activeQ;
      aite_tb_t tbSel;
      aite_cfg_t cfg;
      aite_stat_t stat;

      assign weE = dataWr && !aAddrQ[8] && aAddrQ[7:5] == 3'(e);
      assign startP = weE && aAddrQ[4:0] == `AITE_OFS_CTRL && hwdata[`AITE_CTRL_START];
      assign abortP = weE && aAddrQ[4:0] == `AITE_OFS_CTRL && hwdata[`AITE_CTRL_ABORT];

      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            ctrlQ <= `AITE_CTRL_RST;
            divQ <= `AITE_DIV_RST;
            bufQ <= `AITE_GEN_RST;
            preQ <= `AITE_GEN_RST;
            trigQ <= `AITE_GEN_RST;
            slotQ <= `AITE_GEN_RST;
            chanQ <= `AITE_GEN_RST;
         end else if (weE) begin
            unique case (aAddrQ[4:0])
               `AITE_OFS_CTRL: ctrlQ <= {hwdata[31:2], 2'b00};
               `AITE_OFS_DIV: divQ <= hwdata;
               `AITE_OFS_BUFLEN: bufQ <= hwdata;
               `AITE_OFS_PRE: preQ <= hwdata;
               `AITE_OFS_TRIG: trigQ <= hwdata;
               `AITE_OFS_SLOTS: slotQ <= hwdata;
               `AITE_OFS_CHANS: chanQ <= hwdata;
               default: begin
               end
            endcase
         end
      end

      always_comb begin
         unique case (aAddrQ[4:0])
            `AITE_OFS_CTRL: rdEng[e] = ctrlQ;
            `AITE_OFS_DIV: rdEng[e] = divQ;
            `AITE_OFS_BUFLEN: rdEng[e] = bufQ;
            `AITE_OFS_PRE: rdEng[e] = preQ;
            `AITE_OFS_TRIG: rdEng[e] = trigQ;
            `AITE_OFS_SLOTS: rdEng[e] = slotQ;
            `AITE_OFS_CHANS: rdEng[e] = chanQ;
            `AITE_OFS_STAT: rdEng[e] = {stat.wrPtr, 10'h000, stat.paused, stat.trig,
                                        stat.done, stat.state};
            default: rdEng[e] = 32'h0000_0000;
         endcase
      end

      // An explicit selection wins; otherwise the fastest requested timebase.
      always_comb begin
         if (ctrlQ[`AITE_CTRL_TBSEL] != 2'b00) begin
            tbSel = aite_tb_t'(ctrlQ[`AITE_CTRL_TBSEL]);
         end else if (ctrlQ[4]) begin
            tbSel = TB_13M1;
         end else if (ctrlQ[3]) begin
            tbSel = TB_12M8;
         end else if (ctrlQ[2]) begin
            tbSel = TB_10M;
         end else begin
            tbSel = TB_CORE;
         end
      end

      // With delta-sigma modules present their sample clock paces the whole task.
      assign tickE[e] = (slotQ[`AITE_SLOT_DS] != 8'h00) ?
                        |(dsSampleClk & slotQ[`AITE_SLOT_DS]) :
                        (tbSel == TB_CORE) ? 1'b1 : tbTick[tbSel - 2'b01];

      assign cfg = '{div: divQ[`AITE_DIV_SAMPLE], bufLen: bufQ[15:0], pre: preQ[15:0],
                     refSrc: trigQ[`AITE_TRIG_REFSRC], refFall: trigQ[`AITE_TRIG_REFFALL],
                     refEn: trigQ[`AITE_TRIG_REFEN], pauseSrc: trigQ[`AITE_TRIG_PSRC],
                     pauseLow: trigQ[`AITE_TRIG_PLOW], pauseEn: trigQ[`AITE_TRIG_PEN]};
      assign invE[e] = trigQ[`AITE_TRIG_REFINV];

      aite_engine u_eng (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .cfg(cfg),
         .start(startP),
         .abort(abortP),
         .tick(tickE[e]),
         .srcVec(srcVec),
         .samplePulse(sampleE[e]),
         .refPulse(refE[e]),
         .bufOut(bufPort[e]),
         .stat(stat)
      );

      assign maxCh = maxChans(chanQ, slotQ[`AITE_SLOT_SCAN]);
      assign padded = ctrlQ[`AITE_CTRL_FAST] + `AITE_PAD_CYC;
      assign need = 20'(padded) * 20'(maxCh);
      assign even = (maxCh == 4'h0) ? lastPerQ : lastPerQ / 16'(maxCh);
      // The period is only known after two sample pulses; until then padding is used.
      assign spacing = (divQ[`AITE_DIV_CONV] != 16'h0000) ? divQ[`AITE_DIV_CONV] :
                       (lastPerQ != 16'h0000 && need > 20'(lastPerQ)) ? even : padded;
      assign emit = activeQ && gapQ == 16'h0000;

      always_ff @(posedge core_clk) begin
         if (sys_rst || startP) begin
            perCntQ <= 16'h0000;
            lastPerQ <= 16'h0000;
         end else if (sampleE[e]) begin
            perCntQ <= 16'h0001;
            lastPerQ <= perCntQ;
         end else if (perCntQ != 16'hFFFF && perCntQ != 16'h0000) begin
            perCntQ <= perCntQ + 16'h0001;
         end
      end

      always_ff @(posedge core_clk) begin
         if (sys_rst || abortP) begin
            activeQ <= 1'b0;
            idxQ <= 4'h0;
            gapQ <= 16'h0000;
         end else if (sampleE[e]) begin
            activeQ <= maxCh != 4'h0;
            idxQ <= 4'h0;
            gapQ <= 16'h0000;
         end else if (emit) begin
            idxQ <= idxQ + 4'h1;
            activeQ <= idxQ + 4'h1 < maxCh;
            gapQ <= (spacing == 16'h0000) ? 16'h0000 : spacing - 16'h0001;
         end else if (activeQ) begin
            gapQ <= gapQ - 16'h0001;
         end
      end

      for (genvar s = 0; s < `AITE_NUM_SLOT; s++) begin : g_slot
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               convE[e][s] <= 1'b0;
               sshE[e][s] <= 1'b0;
               syncE[e][s] <= 1'b0;
               slowE[e][s] <= 1'b0;
               repE[e][s] <= 1'b0;
               osE[e][s] <= 1'b0;
            end else begin
               convE[e][s] <= emit && slotQ[s] && idxQ < chanQ[4*s +: 4];
               sshE[e][s] <= sampleE[e] && slotQ[8 + s];
               syncE[e][s] <= startP && slotQ[16 + s];
               osE[e][s] <= slotQ[16 + s] && tbSel != TB_CORE &&
                            tbTick[tbSel - 2'b01];
               // Commit takes the first reading; afterwards a busy module is not retriggered.
               slowE[e][s] <= slotQ[24 + s] && (startP ||
                              (sampleE[e] && !slowBusy[s]));
               repE[e][s] <= slotQ[24 + s] && sampleE[e] && slowBusy[s];
            end
         end
      end
   end

   // Each slot belongs to one task, so the engines' pulses are merged by OR.
   always_comb begin
      convPulse = 8'h00;
      simultaneousSampleHold = 8'h00;
      dsSync = 8'h00;
      osTick = 8'h00;
      slowSample = 8'h00;
      sampleRepeat = 8'h00;
      for (int e = 0; e < `AITE_NUM_ENG; e++) begin
         convPulse = convPulse | convE[e];
         simultaneousSampleHold = simultaneousSampleHold | sshE[e];
         dsSync = dsSync | syncE[e];
         osTick = osTick | osE[e];
         slowSample = slowSample | slowE[e];
         sampleRepeat = sampleRepeat | repE[e];
      end
   end

   for (genvar t = 0; t < 8; t++) begin : g_term
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            pfiOutQ[t] <= 1'b0;
         end else begin
            pfiOutQ[t] <= routeQ[4*t + 3] &&
                          (refE[routeQ[4*t +: 3]] ^ invE[routeQ[4*t +: 3]]);
         end
      end
      assign programmableFunctionTerminalOe[t] = routeQ[4*t + 3];
   end
   assign programmableFunctionTerminalOut = pfiOutQ;
endmodule
`default_nettype wire

//--- aite_properties.sv
// Checker of the timing engine port behaviour.
`timescale 1ns/1ps
`default_nettype none
module aite_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Slots and terminals
   input wire logic [2:0] tbTick,
   input wire logic [7:0] programmableFunctionTerminalOut,
   input wire logic [7:0] programmableFunctionTerminalOe,
   input wire logic [7:0] convPulse,
   input wire logic [7:0] dsSync,
   input wire logic [7:0] osTick
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic rdTake, wrTake, rdPh1_q, rdPh2_q;
   assign rdTake = hsel && hready && htrans[1] && !hwrite;
   assign wrTake = hsel && hready && htrans[1] && hwrite;
   // Read data may only change in the two cycles after a read is taken.
   always_ff @(posedge core_clk) begin
      rdPh1_q <= rdTake && !sys_rst;
      rdPh2_q <= rdPh1_q;
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("Bus response was not OKAY.");
   a_read_wait: assert property (rdTake |=> !hreadyout ##1 hreadyout)
      else $error("Read did not take exactly one wait cycle.");
   a_write_nowait: assert property (wrTake |=> hreadyout)
      else $error("Write data phase was stalled.");
   a_rdata_hold: assert property (!rdPh1_q && !rdPh2_q |-> $stable(hrdata))
      else $error("Read data changed without a read.");
   a_conv_single: assert property ((convPulse & $past(convPulse)) == 8'h00)
      else $error("Convert pulse lasted two cycles.");
   a_sync_single: assert property ((dsSync & $past(dsSync)) == 8'h00)
      else $error("Sync pulse lasted two cycles.");
   a_route_enabled: assert property (
      (programmableFunctionTerminalOut & ~programmableFunctionTerminalOe) == 8'h00)
      else $error("Terminal pulsed without its route enabled.");
   a_os_source: assert property (|osTick |-> $past(|tbTick))
      else $error("Oversample tick without a timebase tick.");
   cover property (|convPulse);
   cover property (|programmableFunctionTerminalOut);
   cover property (|dsSync);
endmodule
bind aite_top aite_properties u_chk (.core_clk, .sys_rst, .hsel, .htrans, .hwrite, .hready,
   .hrdata, .hreadyout, .hresp, .tbTick, .programmableFunctionTerminalOut,
   .programmableFunctionTerminalOe, .convPulse, .dsSync, .osTick);
`default_nettype wire

//--- aite_partner.sv
// Behavioural model of the converter modules that sit in the slots.
`timescale 1ns/1ps
`default_nettype none
module aite_partner #(parameter int OS_DIV = 4, parameter int SLOW_CYC = 30) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Slot pulses from the engines
   input wire logic [7:0] dsSync,
   input wire logic [7:0] osTick,
   input wire logic [7:0] slowSample,
   // Slot answers
   output logic [7:0] dsSampleClk,
   output logic [7:0] slowBusy
);
   int osCnt[8];
   int busyCnt[8];
   always @(posedge core_clk) begin
      for (int s = 0; s < 8; s++) begin
         dsSampleClk[s] <= !sys_rst && !dsSync[s] && osTick[s] && (osCnt[s] == OS_DIV - 1);
         if (sys_rst || dsSync[s]) begin
            osCnt[s] <= 0;
         end else if (osTick[s]) begin
            osCnt[s] <= (osCnt[s] + 1) % OS_DIV;
         end
         if (sys_rst) begin
            busyCnt[s] <= 0;
         end else if (slowSample[s]) begin
            busyCnt[s] <= SLOW_CYC;
         end else if (busyCnt[s] > 0) begin
            busyCnt[s] <= busyCnt[s] - 1;
         end
      end
   end
   always_comb begin
      for (int s = 0; s < 8; s++) begin
         slowBusy[s] = (busyCnt[s] != 0);
      end
   end
endmodule
`default_nettype wire

//--- ai_trigger_timing_engine_tb.sv
// Self-checking bench of the analog input timing engines.
`timescale 1ns/1ps
`default_nettype none
module ai_trigger_timing_engine_tb;
   import aite_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic [2:0] tbTick = 3'h0;
   logic [7:0] programmableFunctionTerminalIn = 8'h00, internalSig = 8'h00, cmpEv = 8'h00;
   logic [7:0] programmableFunctionTerminalOut, programmableFunctionTerminalOe;
   logic [7:0] convPulse, simultaneousSampleHold, dsSync, osTick, dsSampleClk;
   logic [7:0] slowSample, slowBusy, sampleRepeat;
   logic hreadyout, hresp;
   logic [15:0] addr9;
   aite_buf_t [7:0] bufPort;
   int errors = 0, n_checks = 0, cyc = 0, wrCnt, wr2Cnt, cvCnt, sshCnt, syncCnt, refCnt;
   int cvT[2], slowCnt, repCnt;
   logic [31:0] rows[7][3] = '{'{32'h48, 32'h123, 32'h123}, '{32'h4C, 32'h45, 32'h45},
      '{32'hF0, 32'h7FFF, 32'h7FFF}, '{32'hF8, 32'h8765_4321, 32'h8765_4321},
      '{32'h100, 32'h80, 32'h80}, '{32'h1C, 32'hFFFF_FFFF, 32'h0}, '{32'h104, 32'hF, 32'h0}};
   aite_top u_dut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .tbTick,
      .programmableFunctionTerminalIn, .internalSig, .compareEvent(cmpEv),
      .programmableFunctionTerminalOut, .programmableFunctionTerminalOe, .convPulse,
      .simultaneousSampleHold, .dsSync, .osTick, .dsSampleClk, .slowSample, .slowBusy,
      .sampleRepeat, .bufPort);
   aite_partner u_mod (.core_clk, .sys_rst, .dsSync, .osTick, .slowSample, .dsSampleClk,
      .slowBusy);
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      tbTick <= {1'b0, ~tbTick[1], 1'b0};
      if (clr) begin
         {wrCnt, wr2Cnt, cvCnt, sshCnt, syncCnt, refCnt, slowCnt, repCnt} <= '0;
      end else begin
         wrCnt <= wrCnt + int'(bufPort[0].wr);
         slowCnt <= slowCnt + int'(slowSample[5]);
         repCnt <= repCnt + int'(sampleRepeat[5]);
         wr2Cnt <= wr2Cnt + int'(bufPort[2].wr);
         sshCnt <= sshCnt + int'(simultaneousSampleHold[1]);
         syncCnt <= syncCnt + int'(dsSync[3]);
         refCnt <= refCnt + int'(programmableFunctionTerminalOut[1]);
         if (bufPort[0].wr && wrCnt == 8) addr9 <= bufPort[0].addr;
         if (convPulse[0]) begin
            cvCnt <= cvCnt + 1;
            if (cvCnt < 2) cvT[cvCnt] <= cyc;
         end
      end
   end
   task final_report();
      $display("Checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do begin @(posedge core_clk); n++; end while (!hreadyout && n < 100);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin @(posedge core_clk); n++; end while (!hreadyout && n < 100);
      r = hrdata;
      if (n >= 100) begin errors++; final_report(); end
   endtask
   task go(input logic [31:0] a, input logic [31:0] d);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      ahb(1'b1, a, d);
   endtask
   task waitCyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task waitDone(input logic [31:0] base);
      int k;
      k = 0;
      do begin ahb(1'b0, base + 32'h1C, 32'h0); k++; end while (r[3] !== 1'b1 && k < 2000);
      if (k >= 2000) begin errors++; final_report(); end
   endtask
   initial begin
      waitCyc(3);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      ahb(1'b0, 32'h04, 32'h0);
      chk("div reset", r, 32'h1);
      ahb(1'b0, 32'h00, 32'h0);
      chk("ctrl reset", r, 32'h0);
      foreach (rows[i]) begin
         ahb(1'b1, rows[i][0], rows[i][1]);
         ahb(1'b0, rows[i][0], 32'h0);
         chk("reg row", r, rows[i][2]);
      end
      // Reference acquisition; the early edge must leave no trace.
      ahb(1'b1, 32'h04, 32'h4);
      ahb(1'b1, 32'h08, 32'h8);
      ahb(1'b1, 32'h0C, 32'h3);
      ahb(1'b1, 32'h10, 32'h40);
      go(32'h00, 32'h1);
      for (int k = 0; k < 500 && wrCnt < 1; k++) @(posedge core_clk);
      programmableFunctionTerminalIn[0] <= 1'b1;
      waitCyc(2);
      programmableFunctionTerminalIn[0] <= 1'b0;
      for (int k = 0; k < 500 && wrCnt < 10; k++) @(posedge core_clk);
      programmableFunctionTerminalIn[0] <= 1'b1;
      waitDone(32'h0);
      chk("wrap addr", {16'h0, addr9}, 32'h0);
      chk("state", {27'h0, r[4:0]}, 32'h1C);
      waitCyc(40);
      chk("samples", wrCnt, 32'd10 + 32'd8 - 32'd3);
      chk("ref out", refCnt, 32'd1);
      chk("ref oe", {31'h0, programmableFunctionTerminalOe[1]}, 32'h1);
      programmableFunctionTerminalIn[0] <= 1'b0;
      // Pause level is set before start, so an edge detector would miss it.
      ahb(1'b1, 32'h08, 32'h100);
      for (int p = 0; p < 2; p++) begin
         ahb(1'b1, 32'h10, 32'h4800 | (p << 13));
         internalSig[0] <= (p == 0);
         go(32'h00, 32'h1);
         waitCyc(40);
         chk("paused", wrCnt, 32'd0);
         internalSig[0] <= (p != 0);
         waitCyc(40);
         chk("resumed", 32'(wrCnt > 0), 32'd1);
         ahb(1'b1, 32'h00, 32'h2);
      end
      ahb(1'b1, 32'h10, 32'h0);
      ahb(1'b1, 32'h14, 32'h201);
      ahb(1'b1, 32'h18, 32'h3);
      ahb(1'b1, 32'h08, 32'h2);
      for (int j = 0; j < 2; j++) begin
         ahb(1'b1, 32'h04, j ? 32'h0032_03E8 : 32'h0000_03E8);
         go(32'h00, 32'h1001);
         waitDone(32'h0);
         waitCyc(500);
         chk("conv count", cvCnt, 32'd6);
         chk("conv gap", cvT[1] - cvT[0],
             j ? 32'd50 : 32'd16 + 32'd10000 / 32'd50);
         chk("ssh count", sshCnt, 32'd2);
      end
      // Analog reference on its falling edge; the rising edge before it must not count.
      ahb(1'b1, 32'h0C, 32'h0);
      ahb(1'b1, 32'h10, 32'h72);
      go(32'h00, 32'h1);
      cmpEv[2] <= 1'b1;
      waitCyc(4);
      ahb(1'b0, 32'h1C, 32'h0);
      chk("cmp rise", {31'h0, r[4]}, 32'h0);
      cmpEv[2] <= 1'b0;
      waitDone(32'h0);
      waitCyc(40);
      chk("cmp fall", {31'h0, r[4]}, 32'h1);
      chk("cmp ref out", refCnt, 32'd1);
      chk("cmp samples", wrCnt, 32'd2);
      ahb(1'b1, 32'h14, 32'h0);
      ahb(1'b1, 32'h54, 32'h2008_0000);
      ahb(1'b1, 32'h48, 32'h4);
      ahb(1'b1, 32'h4C, 32'h0);
      ahb(1'b1, 32'h44, 32'h1);
      // Only the 12.8 MHz timebase ticks, so picking the slower request would stall.
      go(32'h40, 32'hD);
      waitCyc(3);
      chk("slow commit", slowCnt, 32'd1);
      chk("slow first", wr2Cnt, 32'd0);
      waitDone(32'h40);
      waitCyc(40);
      chk("ds sync", syncCnt, 32'd1);
      chk("ds samples", wr2Cnt, 32'd4);
      chk("slow total", slowCnt + repCnt, 32'd5);
      chk("slow repeat", 32'(repCnt > 0), 32'd1);
      final_report();
   end
endmodule
`default_nettype wire
